// >>> design/awt_params.svh
// register map, field positions and reset values of the converter control
`ifndef AWT_PARAMS_SVH
`define AWT_PARAMS_SVH

`define AWT_OFS_SETUP      8'h04
`define AWT_OFS_WINDOW_COMPARE_CONTROL    8'h08
`define AWT_OFS_SOFTWARE_TRIGGER     8'h0C
`define AWT_OFS_INSEL      8'h10
`define AWT_OFS_RESULT     8'h18
`define AWT_OFS_LOWER      8'h1C
`define AWT_OFS_UPPER      8'h20
`define AWT_OFS_GAIN       8'h24
`define AWT_OFS_OFFSET     8'h28
`define AWT_OFS_INT_STAT   8'h30
`define AWT_OFS_INT_CLR    8'h34
`define AWT_OFS_INT_EN     8'h38

`define AWT_SETUP_DIFF     0
`define AWT_SETUP_LEFT     1
`define AWT_SETUP_FREE     2
`define AWT_SETUP_CORR     3
`define AWT_SETUP_RES_LSB  4
`define AWT_SETUP_RES_MSB  5
`define AWT_SW_FLUSH       0
`define AWT_SW_START       1
`define AWT_INSEL_NEG_LSB  8
`define AWT_INT_DONE       0
`define AWT_INT_WIN        1
`define AWT_XTRA_MSB       3

`define AWT_RST_SETUP      6'h00
`define AWT_RST_WINDOW_COMPARE_CONTROL    3'h0
`define AWT_RST_RESULT     16'h0000
`define AWT_RST_THRESH     16'h0000
`define AWT_RST_GAIN       12'h800
`define AWT_RST_OFFSET     12'h000
`define AWT_GAIN_FRAC      11

`endif

// >>> design/awt_pkg.sv
// types shared by the converter control modules
package awt_pkg;

    typedef enum logic [1:0]
    {
        AWT_ST_IDLE = 2'b00,
        AWT_ST_CONV = 2'b01,
        AWT_ST_CORR = 2'b10,
        AWT_ST_DONE = 2'b11
    } awt_state_e;

    typedef enum logic [1:0]
    {
        AWT_RES_12 = 2'b00,
        AWT_RES_16 = 2'b01,
        AWT_RES_10 = 2'b10,
        AWT_RES_8  = 2'b11
    } awt_res_e;

    typedef enum logic [2:0]
    {
        AWT_WIN_OFF     = 3'b000,
        AWT_WIN_ABOVE   = 3'b001,
        AWT_WIN_BELOW   = 3'b010,
        AWT_WIN_INSIDE  = 3'b011,
        AWT_WIN_OUTSIDE = 3'b100
    } awt_win_e;

endpackage

// >>> design/awt_fmt_if.sv
// link between the sequencer and the result formatter
`timescale 1ns/10ps
`default_nettype none
interface awt_fmt_if;
    logic [15:0]       raw;
    awt_pkg::awt_res_e res_sel;
    logic              corr_en;
    logic              left_align;
    logic [11:0]       gain;
    logic [11:0]       offset;
    logic [2:0]        win_mode;
    logic [15:0]       lower;
    logic [15:0]       upper;
    logic [15:0]       result;
    logic              win_hit;

    modport ctrl (output raw, res_sel, corr_en, left_align, gain, offset,
                  output win_mode, lower, upper, input result, win_hit);
    modport fmt  (input raw, res_sel, corr_en, left_align, gain, offset,
                  input win_mode, lower, upper, output result, win_hit);
endinterface
`default_nettype wire

// >>> design/awt_result_fmt.sv
// correction, alignment and window compare of one conversion result
`timescale 1ns/10ps
`default_nettype none
`include "awt_params.svh"
module awt_result_fmt
(
    awt_fmt_if.fmt f
);
    logic        [15:0] max_val;
    logic        [3:0]  lshift;
    logic        [15:0] masked;
    logic signed [17:0] diff;
    logic signed [30:0] prod;
    logic signed [30:0] scaled;
    logic        [15:0] corrected;
    logic        [15:0] aligned;

    always_comb
    begin
        case (f.res_sel)
            awt_pkg::AWT_RES_12:
            begin
                max_val = 16'h0FFF;
                lshift  = 4'h4;
            end
            awt_pkg::AWT_RES_16:
            begin
                max_val = 16'hFFFF;
                lshift  = 4'h0;
            end
            awt_pkg::AWT_RES_10:
            begin
                max_val = 16'h03FF;
                lshift  = 4'h6;
            end
            default:
            begin
                max_val = 16'h00FF;
                lshift  = 4'h8;
            end
        endcase
    end

    always_comb
    begin
        masked = f.raw & max_val;
        diff   = $signed({2'b00, masked}) - 18'($signed(f.offset));
        prod   = 31'(diff) * $signed({19'h0_0000, f.gain});
        scaled = prod >>> `AWT_GAIN_FRAC;
        // clamp keeps a wrapped value from reading as full scale
        if (!f.corr_en)
            corrected = masked;
        else if (scaled < 0)
            corrected = 16'h0000;
        else if (scaled > $signed({15'h0000, max_val}))
            corrected = max_val;
        else
            corrected = scaled[15:0];
    end

    always_comb
    begin
        if (f.left_align)
            aligned = corrected << lshift;
        else
            aligned = corrected;
    end

    assign f.result = aligned;

    always_comb
    begin
        case (f.win_mode)
            3'h1:    f.win_hit = aligned > f.lower;
            3'h2:    f.win_hit = aligned < f.upper;
            3'h3:    f.win_hit = (aligned > f.lower) && (aligned < f.upper);
            3'h4:    f.win_hit = !((aligned > f.lower) && (aligned < f.upper));
            default: f.win_hit = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> design/awt_control.sv
// register file and conversion sequencer of the converter control
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "awt_params.svh"
module awt_control
#(
    parameter int MUX_W = 5
)
(
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    // register port
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic [15:0]      reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output var  logic [15:0]      reg_rdata_o,
    // analog core
    output var  logic             conv_start_o,
    output var  logic             conv_abort_o,
    output var  logic [MUX_W-1:0] pos_sel_o,
    output var  logic [MUX_W-1:0] neg_sel_o,
    output var  logic             diff_sel_o,
    output var  logic [1:0]       res_sel_o,
    input  wire logic             conv_done_i,
    input  wire logic [15:0]      conv_data_i,
    // interrupt
    output var  logic             irq_o
);
    // select fields must fit their byte of the input select register
    if (MUX_W < 1 || MUX_W > 8)
    begin : g_bad_mux_w
        $error("awt_control: MUX_W must lie in 1..8");
    end

    awt_pkg::awt_state_e state_reg;
    logic [5:0]          setup_reg;
    logic [2:0]          window_compare_control_reg;
    logic                start_reg;
    logic [15:0]         lower_reg;
    logic [15:0]         upper_reg;
    logic [11:0]         gain_reg;
    logic [11:0]         offset_reg;
    logic [15:0]         raw_reg;
    logic [15:0]         result_reg;
    logic [3:0]          xtra_reg;
    logic [1:0]          int_stat_reg;
    logic [1:0]          int_en_reg;
    logic [1:0]          int_stat_next;
    logic [1:0]          events;
    logic                wr_setup;
    logic                wr_software_trigger;
    logic                wr_window_compare_control;
    logic                wr_int_clr;
    logic                wr_int_en;
    logic                start_wr;
    logic                flush_wr;
    logic                launch;
    logic                restart;
    logic                busy;
    logic                completing;
    logic [15:0]         rd_mux;

    awt_fmt_if fmt_bus ();

    awt_result_fmt u_fmt
    (
        .f (fmt_bus.fmt)
    );

    assign fmt_bus.raw        = raw_reg;
    assign fmt_bus.res_sel    = awt_pkg::awt_res_e'(setup_reg[`AWT_SETUP_RES_MSB:`AWT_SETUP_RES_LSB]);
    assign fmt_bus.corr_en    = setup_reg[`AWT_SETUP_CORR];
    assign fmt_bus.left_align = setup_reg[`AWT_SETUP_LEFT];
    assign fmt_bus.gain       = gain_reg;
    assign fmt_bus.offset     = offset_reg;
    assign fmt_bus.win_mode   = window_compare_control_reg;
    assign fmt_bus.lower      = lower_reg;
    assign fmt_bus.upper      = upper_reg;

    // write decode
    assign wr_setup  = reg_wr_i && (reg_addr_i == `AWT_OFS_SETUP);
    assign wr_software_trigger = reg_wr_i && (reg_addr_i == `AWT_OFS_SOFTWARE_TRIGGER);
    assign wr_window_compare_control = reg_wr_i && (reg_addr_i == `AWT_OFS_WINDOW_COMPARE_CONTROL);
    assign wr_int_clr = reg_wr_i && (reg_addr_i == `AWT_OFS_INT_CLR);
    assign wr_int_en  = reg_wr_i && (reg_addr_i == `AWT_OFS_INT_EN);
    assign start_wr  = wr_software_trigger && reg_wdata_i[`AWT_SW_START];
    assign flush_wr  = wr_software_trigger && reg_wdata_i[`AWT_SW_FLUSH];
    assign busy      = (state_reg != awt_pkg::AWT_ST_IDLE);

    // flush wins over any launch in the same cycle
    assign launch  = (state_reg == awt_pkg::AWT_ST_IDLE) && start_reg && !flush_wr;
    assign restart = (state_reg == awt_pkg::AWT_ST_DONE) && setup_reg[`AWT_SETUP_FREE] && !flush_wr;

    // configuration registers
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            setup_reg   <= `AWT_RST_SETUP;
            window_compare_control_reg <= `AWT_RST_WINDOW_COMPARE_CONTROL;
        end
        else
        begin
            if (wr_setup)
                setup_reg <= reg_wdata_i[5:0];
            if (wr_window_compare_control)
                window_compare_control_reg <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            lower_reg  <= `AWT_RST_THRESH;
            upper_reg  <= `AWT_RST_THRESH;
            gain_reg   <= `AWT_RST_GAIN;
            offset_reg <= `AWT_RST_OFFSET;
            pos_sel_o  <= '0;
            neg_sel_o  <= '0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `AWT_OFS_LOWER:  lower_reg  <= reg_wdata_i;
                `AWT_OFS_UPPER:  upper_reg  <= reg_wdata_i;
                `AWT_OFS_GAIN:   gain_reg   <= reg_wdata_i[11:0];
                `AWT_OFS_OFFSET: offset_reg <= reg_wdata_i[11:0];
                `AWT_OFS_INSEL:
                begin
                    pos_sel_o <= reg_wdata_i[MUX_W-1:0];
                    neg_sel_o <= reg_wdata_i[`AWT_INSEL_NEG_LSB +: MUX_W];
                end
                default:
                begin
                end
            endcase
        end
    end

    // mode outputs to the analog core follow the setup register
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            diff_sel_o <= 1'b0;
            res_sel_o  <= 2'b00;
        end
        else
        begin
            diff_sel_o <= setup_reg[`AWT_SETUP_DIFF];
            res_sel_o  <= setup_reg[`AWT_SETUP_RES_MSB:`AWT_SETUP_RES_LSB];
        end
    end

    // pending start; flush re-arms it so operation resumes afterwards
    // hardware clear outranks a start write, so nothing queues twice
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            start_reg <= 1'b0;
        else if (flush_wr && (busy || start_reg))
            start_reg <= 1'b1;
        else if (launch)
            start_reg <= 1'b0;
        else if (start_wr)
            start_reg <= 1'b1;
    end

    // conversion sequencer
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            state_reg <= awt_pkg::AWT_ST_IDLE;
        else if (flush_wr)
            state_reg <= awt_pkg::AWT_ST_IDLE;
        else
        begin
            case (state_reg)
                awt_pkg::AWT_ST_IDLE:
                begin
                    if (launch)
                        state_reg <= awt_pkg::AWT_ST_CONV;
                end
                awt_pkg::AWT_ST_CONV:
                begin
                    if (conv_done_i && setup_reg[`AWT_SETUP_CORR]
                        && (offset_reg[`AWT_XTRA_MSB:0] != 4'h0))
                        state_reg <= awt_pkg::AWT_ST_CORR;
                    else if (conv_done_i)
                        state_reg <= awt_pkg::AWT_ST_DONE;
                end
                awt_pkg::AWT_ST_CORR:
                begin
                    if (xtra_reg == 4'h1)
                        state_reg <= awt_pkg::AWT_ST_DONE;
                end
                awt_pkg::AWT_ST_DONE:
                begin
                    if (restart)
                        state_reg <= awt_pkg::AWT_ST_CONV;
                    else
                        state_reg <= awt_pkg::AWT_ST_IDLE;
                end
                default:
                    state_reg <= awt_pkg::AWT_ST_IDLE;
            endcase
        end
    end

    // extra correction cycles
    // reloaded while converting, so an offset change applies next time
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            xtra_reg <= 4'h0;
        else if (state_reg == awt_pkg::AWT_ST_CONV)
            xtra_reg <= offset_reg[`AWT_XTRA_MSB:0];
        else if (state_reg == awt_pkg::AWT_ST_CORR)
            xtra_reg <= xtra_reg - 4'h1;
    end

    // raw sample is only taken while converting, so a flushed one never lands
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            raw_reg <= 16'h0000;
        else if (state_reg == awt_pkg::AWT_ST_CONV && conv_done_i && !flush_wr)
            raw_reg <= conv_data_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            result_reg <= `AWT_RST_RESULT;
        else if (completing)
            result_reg <= fmt_bus.result;
    end

    // start and abort strobes to the analog core
    // launch and restart never coincide, one strobe serves both
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            conv_start_o <= 1'b0;
            conv_abort_o <= 1'b0;
        end
        else
        begin
            conv_start_o <= launch || restart;
            conv_abort_o <= flush_wr && busy;
        end
    end

    // a completion cancelled by a flush raises no status
    assign completing = (state_reg == awt_pkg::AWT_ST_DONE) && !flush_wr;

    // interrupt status: set wins over a clear in the same cycle
    always_comb
    begin
        events                = 2'b00;
        events[`AWT_INT_DONE] = completing;
        events[`AWT_INT_WIN]  = completing && fmt_bus.win_hit;
    end

    always_comb
    begin
        int_stat_next = int_stat_reg;
        if (wr_int_clr)
            int_stat_next = int_stat_next & ~reg_wdata_i[1:0];
        int_stat_next = int_stat_next | events;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            int_stat_reg <= 2'b00;
            int_en_reg   <= 2'b00;
            irq_o        <= 1'b0;
        end
        else
        begin
            int_stat_reg <= int_stat_next;
            if (wr_int_en)
                int_en_reg <= reg_wdata_i[1:0];
            irq_o <= |(int_stat_reg & int_en_reg);
        end
    end

    // read path, unmapped reads return zero
    always_comb
    begin
        case (reg_addr_i)
            `AWT_OFS_SETUP:    rd_mux = {10'h000, setup_reg};
            `AWT_OFS_WINDOW_COMPARE_CONTROL:  rd_mux = {13'h0000, window_compare_control_reg};
            `AWT_OFS_SOFTWARE_TRIGGER:   rd_mux = {14'h0000, start_reg, 1'b0};
            `AWT_OFS_INSEL:    rd_mux = 16'({neg_sel_o, 8'(pos_sel_o)});
            `AWT_OFS_RESULT:   rd_mux = result_reg;
            `AWT_OFS_LOWER:    rd_mux = lower_reg;
            `AWT_OFS_UPPER:    rd_mux = upper_reg;
            `AWT_OFS_GAIN:     rd_mux = {4'h0, gain_reg};
            `AWT_OFS_OFFSET:   rd_mux = {4'h0, offset_reg};
            `AWT_OFS_INT_STAT: rd_mux = {14'h0000, int_stat_reg};
            `AWT_OFS_INT_EN:   rd_mux = {14'h0000, int_en_reg};
            default:           rd_mux = 16'h0000;
        endcase
    end

    // zero outside the answer cycle so a stale word never lingers
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
            reg_rdata_o <= rd_mux;
        else
            reg_rdata_o <= 16'h0000;
    end
endmodule
`default_nettype wire

// >>> sim/awt_properties.sv
// port-level assertions on the converter control
`timescale 1ns/10ps
`default_nettype none
module awt_properties
#(
    parameter int MUX_W = 5
)
(
    // clock and reset
    input wire logic             core_clk_i,
    input wire logic             nrst_i,
    // register port
    input wire logic [7:0]       reg_addr_i,
    input wire logic [15:0]      reg_wdata_i,
    input wire logic             reg_wr_i,
    input wire logic             reg_rd_i,
    input wire logic [15:0]      reg_rdata_o,
    // analog core
    input wire logic             conv_start_o,
    input wire logic             conv_abort_o,
    input wire logic [MUX_W-1:0] pos_sel_o,
    input wire logic [MUX_W-1:0] neg_sel_o,
    input wire logic             diff_sel_o,
    input wire logic [1:0]       res_sel_o,
    input wire logic             conv_done_i,
    input wire logic [15:0]      conv_data_i,
    // interrupt
    input wire logic             irq_o
);
    logic act_reg;
    logic pend_reg;
    logic free_reg;
    logic corr_reg;
    logic sw_wr;

    assign sw_wr = reg_wr_i && reg_addr_i == 8'h0C;

    // done is only meaningful while a launched conversion is open
    always_ff @(posedge core_clk_i)
        if (!nrst_i)
        begin
            act_reg  <= 1'b0;
            pend_reg <= 1'b0;
        end
        else
        begin
            act_reg  <= conv_start_o || (act_reg && !conv_done_i && !conv_abort_o);
            pend_reg <= (sw_wr && reg_wdata_i[1]) || (pend_reg && !conv_start_o);
        end

    always_ff @(posedge core_clk_i)
        if (!nrst_i)
            {free_reg, corr_reg} <= 2'b00;
        else if (reg_wr_i && reg_addr_i == 8'h04)
            {free_reg, corr_reg} <= {reg_wdata_i[2], reg_wdata_i[3]};

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_RES_FOLLOW:
    assert property (reg_wr_i && reg_addr_i == 8'h04 |=> ##1 res_sel_o == $past(reg_wdata_i[5:4], 2))
    else $error("resolution code not forwarded");
    AST_DIFF_FOLLOW:
    assert property (reg_wr_i && reg_addr_i == 8'h04 |=> ##1 diff_sel_o == $past(reg_wdata_i[0], 2))
    else $error("differential select not forwarded");
    AST_LAUNCH:
    assert property (sw_wr && reg_wdata_i[1:0] == 2'b10 && !act_reg && !pend_reg && !conv_start_o
                     && !free_reg && !corr_reg |-> ##2 conv_start_o)
    else $error("start write did not launch");
    AST_START_ONCE:
    assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
    AST_SINGLE_STOP:
    assert property (act_reg && conv_done_i && !free_reg && !pend_reg && !sw_wr && !conv_abort_o
                     |=> !conv_start_o [*2])
    else $error("single mode restarted by itself");
    AST_FREE_RESTART:
    assert property (act_reg && conv_done_i && free_reg && !corr_reg && !conv_abort_o |-> ##2 conv_start_o)
    else $error("free run did not restart");
    AST_ABORT_CAUSE:
    assert property (conv_abort_o |-> $past(sw_wr && reg_wdata_i[0]))
    else $error("abort without flush");
    AST_FLUSH_RESTART:
    assert property (conv_abort_o |-> ##[1:2] conv_start_o)
    else $error("no fresh conversion after flush");
    AST_IRQ_FALL:
    assert property ($fell(irq_o) |-> $past(reg_wr_i, 2))
    else $error("interrupt dropped without a write");
endmodule

bind awt_control awt_properties #(.MUX_W(MUX_W)) u_props
(
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o),
    .conv_abort_o(conv_abort_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o), .diff_sel_o(diff_sel_o),
    .res_sel_o(res_sel_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .irq_o(irq_o)
);
`default_nettype wire

// >>> sim/awt_analog_model.sv
// behavioural analog conversion core facing the converter control
`timescale 1ns/10ps
`default_nettype none
module awt_analog_model
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    // control from the block
    input  wire logic        conv_start_i,
    input  wire logic        conv_abort_i,
    input  wire logic [1:0]  res_sel_i,
    // bench settings
    input  wire logic [15:0] sample_i,
    input  wire logic [3:0]  lat_i,
    // result to the block
    output var  logic        conv_done_o,
    output var  logic [15:0] conv_data_o
);
    logic [3:0]  cnt_reg;
    logic [15:0] mask;

    always_comb
        case (res_sel_i)
            2'b00:   mask = 16'h0FFF;
            2'b01:   mask = 16'hFFFF;
            2'b10:   mask = 16'h03FF;
            default: mask = 16'h00FF;
        endcase

    // data toggles outside the done cycle so a late sample never matches
    always_ff @(posedge core_clk_i)
        if (!nrst_i)
        begin
            cnt_reg     <= 4'h0;
            conv_done_o <= 1'b0;
            conv_data_o <= 16'h0000;
        end
        else
        begin
            conv_done_o <= 1'b0;
            conv_data_o <= ~conv_data_o;
            if (conv_abort_i)
                cnt_reg <= 4'h0;
            else if (conv_start_i)
                cnt_reg <= lat_i;
            else if (cnt_reg == 4'h1)
            begin
                cnt_reg     <= 4'h0;
                conv_done_o <= 1'b1;
                conv_data_o <= sample_i & mask;
            end
            else if (cnt_reg != 4'h0)
                cnt_reg <= cnt_reg - 4'h1;
        end
endmodule
`default_nettype wire

// >>> sim/test_adc_control_window_trigger.sv
// self-checking bench for the converter control
`timescale 1ns/10ps
`default_nettype none
module test_adc_control_window_trigger;
    logic        core_clk, nrst, wr, rd, start, abort, diff, done, irq;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, data, smp, v;
    logic [1:0]  res;
    logic [4:0]  pos, neg;
    logic [3:0]  lat;
    int          error_cnt, total_checks;

    awt_control #(.MUX_W(5)) dut
    (
        .core_clk_i  (core_clk),
        .nrst_i      (nrst),
        .reg_addr_i  (addr),
        .reg_wdata_i (wdata),
        .reg_wr_i    (wr),
        .reg_rd_i    (rd),
        .reg_rdata_o (rdata),
        .conv_start_o(start),
        .conv_abort_o(abort),
        .pos_sel_o   (pos),
        .neg_sel_o   (neg),
        .diff_sel_o  (diff),
        .res_sel_o   (res),
        .conv_done_i (done),
        .conv_data_i (data),
        .irq_o       (irq)
    );
    awt_analog_model u_ana
    (
        .core_clk_i  (core_clk),
        .nrst_i      (nrst),
        .conv_start_i(start),
        .conv_abort_i(abort),
        .res_sel_i   (res),
        .sample_i    (smp),
        .lat_i       (lat),
        .conv_done_o (done),
        .conv_data_o (data)
    );

    task report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 v = rdata;
        chk(v, e);
    endtask
    task wait_done;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge core_clk);
            if (done === 1'b1)
                return;
        end
        chk(16'h0001, 16'h0000);
    endtask
    // launch one conversion and leave a spare cycle for the result write
    task conv(input logic [15:0] s);
        smp <= s;
        wr_reg(8'h0C, 16'h0002);
        wait_done;
        @(posedge core_clk);
    endtask

    task t_reset;
        rchk(8'h08, 16'h0000);
        rchk(8'h0C, 16'h0000);
        rchk(8'h04, 16'h0000);
        rchk(8'h18, 16'h0000);
        rchk(8'h3C, 16'h0000);
        wr_reg(8'h10, 16'h0A15);
        rchk(8'h10, 16'h0A15);
        chk({11'h000, pos}, 16'h0015);
        chk({11'h000, neg}, 16'h000A);
        wr_reg(8'h08, 16'h00FF);
        rchk(8'h08, 16'h0007);
        wr_reg(8'h18, 16'h1234);
        rchk(8'h18, 16'h0000);
    endtask
    task t_trigger;
        int n;
        n = 0;
        wr_reg(8'h0C, 16'h0000);
        repeat (6) @(posedge core_clk) n += int'(start);
        chk(16'(n), 16'h0000);
        lat <= 4'h6;
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= 8'h0C;
        wdata <= 16'h0002;
        @(posedge core_clk);
        @(posedge core_clk);
        wr <= 1'b0;
        repeat (30) @(posedge core_clk) n += int'(start);
        chk(16'(n), 16'h0001);
        rchk(8'h0C, 16'h0000);
    endtask
    task t_format;
        int          w;
        logic [15:0] raw;
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(8'h04, 16'((k % 4) << 4) | 16'(k / 4 * 3));
            w = (k % 4 == 0) ? 12 : (k % 4 == 1) ? 16 : (k % 4 == 2) ? 10 : 8;
            raw = 16'hABCD & 16'((32'h1 << w) - 1);
            conv(16'hABCD);
            chk({14'h0000, res}, 16'(k % 4));
            chk({15'h0000, diff}, 16'(k / 4));
            rchk(8'h18, (k >= 4) ? 16'(raw << (16 - w)) : raw);
        end
        wr_reg(8'h04, 16'h0000);
    endtask
    task t_window;
        logic [15:0] s;
        logic        in_w;
        logic        hit;
        wr_reg(8'h1C, 16'h0100);
        wr_reg(8'h20, 16'h0200);
        wr_reg(8'h38, 16'h0002);
        for (int m = 0; m < 8; m++)
        begin
            wr_reg(8'h08, 16'(m));
            for (int j = 0; j < 3; j++)
            begin
                s = 16'h0100 + 16'(j) * 16'h0080;
                in_w = s > 16'h0100 && s < 16'h0200;
                hit = (m == 1) ? s > 16'h0100 : (m == 2) ? s < 16'h0200 : (m == 3) ? in_w : (m == 4) ? !in_w : 1'b0;
                conv(s);
                rchk(8'h30, {14'h0000, hit, 1'b1});
                chk({15'h0000, irq}, {15'h0000, hit});
                wr_reg(8'h34, 16'h0003);
                repeat (2) @(posedge core_clk);
                chk({15'h0000, irq}, 16'h0000);
            end
        end
        wr_reg(8'h38, 16'h0000);
        wr_reg(8'h08, 16'h0001);
        conv(16'h0180);
        repeat (3) @(posedge core_clk);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(8'h38, 16'h0002);
        repeat (2) @(posedge core_clk);
        chk({15'h0000, irq}, 16'h0001);
    endtask
    // old value two cycles past the plain latency, corrected value later
    task t_corr;
        wr_reg(8'h24, 16'h0400);
        wr_reg(8'h28, 16'h0002);
        wr_reg(8'h04, 16'h0008);
        conv(16'h0100);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= 8'h18;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 chk(rdata, 16'h0180);
        @(posedge core_clk);
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 chk(rdata, 16'h007F);
    endtask
    task t_free;
        int n;
        n = 0;
        lat <= 4'h3;
        smp <= 16'h0123;
        wr_reg(8'h04, 16'h0004);
        wr_reg(8'h0C, 16'h0002);
        repeat (40) @(posedge core_clk) n += int'(start);
        chk(16'(n > 4), 16'h0001);
        lat <= 4'hF;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 20 && start !== 1'b1; i++) @(posedge core_clk);
        smp <= 16'h0456;
        wr_reg(8'h04, 16'h0000);
        wr_reg(8'h0C, 16'h0001);
        n = 0;
        repeat (4)
        begin
            @(posedge core_clk);
            n += int'(abort) + int'(start) * 2;
        end
        chk(16'(n), 16'h0003);
        rchk(8'h18, 16'h0123);
        wait_done;
        @(posedge core_clk);
        rchk(8'h18, 16'h0456);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial
    begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        smp = 16'h0000;
        lat = 4'h4;
        error_cnt = 0;
        total_checks = 0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset;
        t_trigger;
        t_format;
        t_window;
        t_corr;
        t_free;
        report_and_stop;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        report_and_stop;
    end
endmodule
`default_nettype wire
